/* current_channel_sample_path.sv */
`timescale 1ns/1ns
module current_channel_sample_path
   import sample_path_pkg::*;
(
   input  wire logic        sys_clk,
   input  wire logic        rst,
   input  wire logic [23:0] adc_phase_a,
   input  wire logic [23:0] adc_phase_b,
   input  wire logic [23:0] adc_phase_c,
   input  wire logic        adc_strobe,
   input  wire logic        reg_valid,
   input  wire logic [7:0]  reg_addr,
   input  wire logic [23:0] reg_wdata,
   input  wire logic        byte_read,
   output logic [7:0]       reg_rdata,
   output logic             reg_rvalid,
   output logic [1:0]       current_gain,
   output logic [1:0]       voltage_gain,
   output logic             modulator_clock,
   output logic [23:0]      energy_sample_a,
   output logic [23:0]      energy_sample_b,
   output logic [23:0]      energy_sample_c,
   output logic             irq_n_out,
   output logic             irq_n_oe
);
   import sample_path_pkg::*;

   // ========================================================================
   // registers
   logic [7:0]  analog_gain_select;
   logic [11:0] phase_a_power_gain;
   logic [11:0] phase_b_power_gain;
   logic [11:0] phase_c_power_gain;
   logic [7:0]  waveform_mode;
   logic [7:0]  irq_mask;
   logic [7:0]  next_analog_gain_select;
   logic [11:0] next_phase_a_power_gain;
   logic [11:0] next_phase_b_power_gain;
   logic [11:0] next_phase_c_power_gain;
   logic [7:0]  next_waveform_mode;
   logic [7:0]  next_irq_mask;
   logic        sample_ready_mask_bit;
   logic [1:0]  sample_rate_select;
   logic [1:0]  phase_pick;

   always_comb begin
      next_analog_gain_select = analog_gain_select;
      next_phase_a_power_gain = phase_a_power_gain;
      next_phase_b_power_gain = phase_b_power_gain;
      next_phase_c_power_gain = phase_c_power_gain;
      next_waveform_mode      = waveform_mode;
      next_irq_mask           = irq_mask;
      if (reg_valid && reg_addr[7]) begin
         case (reg_addr & ~write_flag)
            addr_analog_gain:   next_analog_gain_select = reg_wdata[7:0];
            addr_phase_a_gain:  next_phase_a_power_gain = reg_wdata[11:0];
            addr_phase_b_gain:  next_phase_b_power_gain = reg_wdata[11:0];
            addr_phase_c_gain:  next_phase_c_power_gain = reg_wdata[11:0];
            addr_waveform_mode: next_waveform_mode      = reg_wdata[7:0];
            addr_irq_mask:      next_irq_mask           = reg_wdata[7:0];
            default: ;
         endcase
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         analog_gain_select <= analog_gain_reset;
         phase_a_power_gain <= power_gain_reset;
         phase_b_power_gain <= power_gain_reset;
         phase_c_power_gain <= power_gain_reset;
         waveform_mode      <= waveform_mode_reset;
         irq_mask           <= irq_mask_reset;
      end else begin
         analog_gain_select <= next_analog_gain_select;
         phase_a_power_gain <= next_phase_a_power_gain;
         phase_b_power_gain <= next_phase_b_power_gain;
         phase_c_power_gain <= next_phase_c_power_gain;
         waveform_mode      <= next_waveform_mode;
         irq_mask           <= next_irq_mask;
      end
   end

   always_comb begin
      sample_ready_mask_bit = irq_mask[sample_mask_bit];
      sample_rate_select    = waveform_mode[rate_select_lsb +: 2];
      phase_pick            = waveform_mode[phase_select_lsb +: 2];
   end

   // ========================================================================
   // pga selects, one code per channel; code 3 passed through unchanged
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         current_gain <= 2'b00;
         voltage_gain <= 2'b00;
      end else begin
         current_gain <= analog_gain_select[current_gain_lsb +: 2];
         voltage_gain <= analog_gain_select[voltage_gain_lsb +: 2];
      end
   end

   // ========================================================================
   // modulator clock: toggle every six cycles gives a divide by twelve
   logic [3:0] mod_count;
   logic [3:0] next_mod_count;
   logic       next_modulator_clock;

   always_comb begin
      next_mod_count       = mod_count + 4'h1;
      next_modulator_clock = modulator_clock;
      if (mod_count == 4'((modulator_divide / 2) - 1)) begin
         next_mod_count       = 4'h0;
         next_modulator_clock = ~modulator_clock;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         mod_count       <= 4'h0;
         modulator_clock <= 1'b0;
      end else begin
         mod_count       <= next_mod_count;
         modulator_clock <= next_modulator_clock;
      end
   end

   // ========================================================================
   // per-phase gain scaling and clamping
   function automatic logic [23:0] scale_clamp(input logic [23:0] adc,
                                               input logic [11:0] gain);
      logic signed [37:0] prod;
      logic signed [37:0] scaled;
      prod   = 38'(signed'(adc)) * 38'(signed'(gain));
      scaled = 38'(signed'(adc)) + (prod >>> 12);
      if (scaled > 38'(clamp_pos)) begin
         scale_clamp = clamp_pos;
      end else if (scaled < 38'(clamp_neg)) begin
         scale_clamp = clamp_neg;
      end else begin
         scale_clamp = scaled[23:0];
      end
   endfunction

   logic [23:0] adc_in   [3];
   logic [11:0] gain_in  [3];
   logic [23:0] scaled   [3];
   logic [23:0] next_scaled [3];

   always_comb begin
      adc_in[0]  = adc_phase_a;
      adc_in[1]  = adc_phase_b;
      adc_in[2]  = adc_phase_c;
      gain_in[0] = phase_a_power_gain;
      gain_in[1] = phase_b_power_gain;
      gain_in[2] = phase_c_power_gain;
   end

   genvar ph;
   generate
      for (ph = 0; ph < 3; ph++) begin : g_phase
         always_comb begin
            next_scaled[ph] = adc_strobe ?
               scale_clamp(adc_in[ph], gain_in[ph]) : scaled[ph];
         end
         always_ff @(posedge sys_clk) begin
            if (rst) begin
               scaled[ph] <= 24'h000000;
            end else begin
               scaled[ph] <= next_scaled[ph];
            end
         end
      end
   endgenerate

   // energy path always sees every scaled sample, independent of waveform
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         energy_sample_a <= 24'h000000;
         energy_sample_b <= 24'h000000;
         energy_sample_c <= 24'h000000;
      end else begin
         energy_sample_a <= scaled[0];
         energy_sample_b <= scaled[1];
         energy_sample_c <= scaled[2];
      end
   end

   // ========================================================================
   // waveform rate timer: 384, 768, 1536, 3072 cycles
   logic [11:0] rate_count;
   logic [11:0] next_rate_count;
   logic [11:0] rate_limit;
   logic        sample_tick;

   always_comb begin
      rate_limit  = 12'((base_period_cycles << sample_rate_select)
                        - 1);
      sample_tick = (rate_count >= rate_limit);
      next_rate_count = sample_tick ? 12'h000 : rate_count + 12'h001;
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         rate_count <= 12'h000;
      end else begin
         rate_count <= next_rate_count;
      end
   end

   // ========================================================================
   // sample fifo and waveform byte readout
   logic [23:0] pick_sample;
   logic        push_valid;
   logic        push_ready;
   logic [23:0] head_data;
   logic        head_valid;
   logic        head_pop;

   always_comb begin
      case (phase_pick)
         2'd0:    pick_sample = scaled[0];
         2'd1:    pick_sample = scaled[1];
         2'd2:    pick_sample = scaled[2];
         default: pick_sample = 24'h000000;
      endcase
      push_valid = sample_tick && sample_ready_mask_bit
                   && (phase_pick != 2'd3);
   end

   sample_fifo #(.width(sample_width), .depth(fifo_depth)) u_fifo (
      .sys_clk   (sys_clk),
      .rst       (rst),
      .in_data   (pick_sample),
      .in_valid  (push_valid),
      .in_ready  (push_ready),
      .out_data  (head_data),
      .out_valid (head_valid),
      .out_ready (head_pop)
   );

   logic [1:0] byte_index;
   logic [1:0] next_byte_index;
   logic       irq_flag;
   logic       next_irq_flag;
   logic       is_wave_read;
   logic       is_status_read;
   logic [7:0] next_reg_rdata;

   always_comb begin
      is_wave_read   = reg_valid && !reg_addr[7] && byte_read
                       && (reg_addr == addr_waveform);
      is_status_read = reg_valid && !reg_addr[7]
                       && (reg_addr == addr_reset_status);
      head_pop        = is_wave_read && (byte_index == 2'd2) && head_valid;
      next_byte_index = byte_index;
      if (is_wave_read) begin
         next_byte_index = (byte_index == 2'd2) ? 2'd0 : byte_index + 2'd1;
      end
      next_reg_rdata = 8'h00;
      case (byte_index)
         2'd0:    next_reg_rdata = head_data[23:16];
         2'd1:    next_reg_rdata = head_data[15:8];
         default: next_reg_rdata = head_data[7:0];
      endcase
      if (is_status_read) begin
         next_reg_rdata = {7'h00, irq_flag};
      end else if (!is_wave_read) begin
         next_reg_rdata = 8'h00;
      end
      // new sample wins over a simultaneous status read
      next_irq_flag = irq_flag;
      if (is_status_read) begin
         next_irq_flag = 1'b0;
      end
      if (push_valid && push_ready) begin
         next_irq_flag = 1'b1;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         byte_index <= 2'd0;
         irq_flag   <= 1'b0;
         reg_rdata  <= 8'h00;
         reg_rvalid <= 1'b0;
         irq_n_out  <= 1'b0;
         irq_n_oe   <= 1'b1;
      end else begin
         byte_index <= next_byte_index;
         irq_flag   <= next_irq_flag;
         reg_rdata  <= next_reg_rdata;
         reg_rvalid <= is_wave_read || is_status_read;
         irq_n_out  <= 1'b0;
         irq_n_oe   <= ~(next_irq_flag && sample_ready_mask_bit);
      end
   end
endmodule

/* sample_path_pkg.sv */
package sample_path_pkg;
   // =========================================================================
   // register offsets (serial port addresses, one byte each)
   localparam logic [7:0] addr_waveform         = 8'h01;
   localparam logic [7:0] addr_analog_gain      = 8'h02;
   localparam logic [7:0] addr_phase_a_gain     = 8'h03;
   localparam logic [7:0] addr_phase_b_gain     = 8'h04;
   localparam logic [7:0] addr_phase_c_gain     = 8'h05;
   localparam logic [7:0] addr_waveform_mode    = 8'h06;
   localparam logic [7:0] addr_irq_mask         = 8'h07;
   localparam logic [7:0] addr_reset_status     = 8'h08;
   localparam logic [7:0] write_flag            = 8'h80;
   // =========================================================================
   // field positions
   localparam int current_gain_lsb  = 0;
   localparam int voltage_gain_lsb  = 5;
   localparam int phase_select_lsb  = 0;
   localparam int rate_select_lsb   = 3;
   localparam int sample_mask_bit   = 0;
   // =========================================================================
   // reset values
   localparam logic [7:0]  analog_gain_reset   = 8'h00;
   localparam logic [11:0] power_gain_reset    = 12'h000;
   localparam logic [7:0]  waveform_mode_reset = 8'h00;
   localparam logic [7:0]  irq_mask_reset      = 8'h00;
   // =========================================================================
   // timing
   localparam int clock_hz          = 10_000_000;
   localparam int modulator_divide  = 12;
   // fastest output rate, about 26.0 kSPS: 384 system clocks per sample
   localparam int fastest_rate_sps  = 26_000;
   localparam int base_period       = clock_hz / fastest_rate_sps;
   localparam int base_period_cycles = (base_period < 1) ? 1 : base_period;
   // =========================================================================
   // data formats
   localparam int sample_width = 24;
   localparam int gain_width   = 12;
   localparam logic signed [23:0] clamp_pos = 24'sh400000;
   localparam logic signed [23:0] clamp_neg = 24'shc00000;
   localparam logic signed [23:0] full_scale_pos = 24'sh28f5c2;
   localparam logic signed [23:0] full_scale_neg = 24'shd70a3e;
   localparam int fifo_depth = 16;

   typedef enum logic [1:0] {
      phase_a_sel, phase_b_sel, phase_c_sel, phase_none_sel
   } phase_select_type;
endpackage

/* sample_fifo.sv */
`timescale 1ns/1ns
module sample_fifo #(
   parameter int width = 24,
   parameter int depth = 16
) (
   input  wire logic             sys_clk,
   input  wire logic             rst,
   input  wire logic [width-1:0] in_data,
   input  wire logic             in_valid,
   output logic                  in_ready,
   output logic      [width-1:0] out_data,
   output logic                  out_valid,
   input  wire logic             out_ready
);
   localparam int aw = $clog2(depth);

   logic [width-1:0] store [depth];
   logic [aw-1:0]    wr_ptr;
   logic [aw-1:0]    rd_ptr;
   logic [aw:0]      count;
   logic [aw-1:0]    next_wr_ptr;
   logic [aw-1:0]    next_rd_ptr;
   logic [aw:0]      next_count;
   logic             push;
   logic             pop;

   always_comb begin
      push = in_valid && in_ready;
      pop  = out_valid && out_ready;
      next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
      next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
      next_count  = count;
      if (push && !pop) begin
         next_count = count + 1'b1;
      end else if (pop && !push) begin
         next_count = count - 1'b1;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count  <= '0;
      end else begin
         wr_ptr <= next_wr_ptr;
         rd_ptr <= next_rd_ptr;
         count  <= next_count;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (push) begin
         store[wr_ptr] <= in_data;
      end
   end

   always_comb begin
      in_ready  = (count != (aw+1)'(depth));
      out_valid = (count != '0);
      out_data  = store[rd_ptr];
   end
endmodule

/* current_channel_sample_path_sva.sv */
`timescale 1ns/1ns
// ==========================================================
// port checker for the current channel sample path
module sample_path_checker
   import sample_path_pkg::*;
(
   input wire logic        sys_clk,
   input wire logic        rst,
   input wire logic        reg_valid,
   input wire logic [7:0]  reg_addr,
   input wire logic [23:0] reg_wdata,
   input wire logic        byte_read,
   input wire logic        reg_rvalid,
   input wire logic [1:0]  current_gain,
   input wire logic [1:0]  voltage_gain,
   input wire logic        modulator_clock,
   input wire logic [23:0] energy_sample_a,
   input wire logic [23:0] energy_sample_b,
   input wire logic [23:0] energy_sample_c,
   input wire logic        irq_n_out,
   input wire logic        irq_n_oe
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);
   logic        mask_q;
   logic        mask_qq;
   logic        st_q;
   wire logic   st_rd = reg_valid && reg_addr == addr_reset_status;
   wire logic   gain_wr = reg_valid
                          && reg_addr == (write_flag | addr_analog_gain);
   always_ff @(posedge sys_clk) begin
      st_q    <= st_rd;
      mask_qq <= mask_q;
      if (rst)
         mask_q <= 1'b0;
      else if (reg_valid && reg_addr == (write_flag | addr_irq_mask))
         mask_q <= reg_wdata[sample_mask_bit];
   end
   function automatic logic in_range(logic [23:0] v);
      return $signed(v) <= clamp_pos && $signed(v) >= clamp_neg;
   endfunction
   sequence s_byte_rd;
      reg_valid && reg_addr == addr_waveform && byte_read;
   endsequence
   sequence s_status_rd;
      st_rd;
   endsequence
   sequence s_half_period;
      (!$fell(modulator_clock)) [*5] ##1 $fell(modulator_clock);
   endsequence
   property p_read_answer;
      (s_byte_rd or s_status_rd) |=> reg_rvalid;
   endproperty
   property p_write_silent;
      reg_valid && reg_addr[7] |=> !reg_rvalid;
   endproperty
   // register lands on the take edge, the pga output one edge later
   property p_current_gain;
      gain_wr |-> ##2 current_gain == $past(reg_wdata[1:0], 2);
   endproperty
   property p_voltage_gain;
      gain_wr |-> ##2 voltage_gain == $past(reg_wdata[6:5], 2);
   endproperty
   property p_mod_clock;
      $rose(modulator_clock) |=> s_half_period;
   endproperty
   property p_irq_clear;
      s_status_rd |-> ##2 irq_n_oe;
   endproperty
   property p_irq_hold;
      // clearing the mask also releases the pin
      !irq_n_oe && mask_q && !st_rd && !st_q |=> !irq_n_oe;
   endproperty
   property p_masked_quiet;
      !mask_q && !mask_qq && irq_n_oe |=> irq_n_oe;
   endproperty
   property p_open_drain;
      irq_n_out == 1'b0;
   endproperty
   property p_clamp;
      in_range(energy_sample_a) && in_range(energy_sample_b)
         && in_range(energy_sample_c);
   endproperty
   property p_reset_idle;
      disable iff (1'b0)
         rst |=> irq_n_oe && !reg_rvalid && current_gain == 2'b00;
   endproperty
   a_read_answer: assert property (p_read_answer)
      else $error("read not answered");
   a_write_silent: assert property (p_write_silent)
      else $error("write answered");
   a_current_gain: assert property (p_current_gain)
      else $error("current gain field wrong");
   a_voltage_gain: assert property (p_voltage_gain)
      else $error("voltage gain field wrong");
   a_mod_clock: assert property (p_mod_clock)
      else $error("modulator clock not divided by twelve");
   a_irq_clear: assert property (p_irq_clear)
      else $error("interrupt not released by status read");
   a_irq_hold: assert property (p_irq_hold)
      else $error("interrupt released without status read");
   a_masked_quiet: assert property (p_masked_quiet)
      else $error("interrupt while masked");
   a_open_drain: assert property (p_open_drain)
      else $error("interrupt pin driven high");
   a_clamp: assert property (p_clamp)
      else $error("sample beyond clamp");
   a_reset_idle: assert property (p_reset_idle)
      else $error("outputs active in reset");
endmodule

/* host_model.sv */
`timescale 1ns/1ns
// ==========================================================
// host side of the register port
module host_model
   import sample_path_pkg::*;
(
   input  wire logic   sys_clk,
   output logic        reg_valid,
   output logic [7:0]  reg_addr,
   output logic [23:0] reg_wdata,
   output logic        byte_read
);
   initial begin
      reg_valid = 1'b0;
      reg_addr  = 8'h00;
      reg_wdata = 24'h000000;
      byte_read = 1'b0;
   end
   task automatic access(input logic [7:0] a, input logic [23:0] d);
      @(posedge sys_clk);
      reg_valid <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= d;
      byte_read <= (a == addr_waveform);
      @(posedge sys_clk);
      reg_valid <= 1'b0;
      // released bus shows no stale value
      reg_addr  <= ~a;
      reg_wdata <= ~d;
      byte_read <= 1'b0;
   endtask
   // one sample, most significant byte first
   task automatic read_sample();
      repeat (3) access(addr_waveform, 24'h000000);
   endtask
   task automatic clear_irq();
      access(addr_reset_status, 24'h000000);
   endtask
endmodule

/* current_channel_sample_path_tb.sv */
`timescale 1ns/1ns
// ==========================================================
// self-checking bench
module current_channel_sample_path_tb;
   import sample_path_pkg::*;
   logic        sys_clk = 1'b0;
   logic        rst = 1'b1;
   logic [23:0] adc_a = 24'h0, adc_b = 24'h0, adc_c = 24'h0;
   logic        adc_strobe = 1'b0;
   wire logic   reg_valid, reg_rvalid, byte_read, modulator_clock;
   wire logic   irq_n_out, irq_n_oe;
   wire logic [7:0]  reg_addr, reg_rdata;
   wire logic [23:0] reg_wdata, energy_sample_a, energy_sample_b;
   wire logic [23:0] energy_sample_c;
   wire logic [1:0]  current_gain, voltage_gain;
   // pull-up on the open-drain line
   wire logic   irq_pin = irq_n_oe ? 1'b1 : irq_n_out;
   int          n_errors = 0, samples_checked = 0, cyc = 0;
   logic [23:0] exp_q[$], en_q[$];
   logic [11:0] gn[3];
   logic [2:0]  stb_d = 3'b000;
   always #50 sys_clk = ~sys_clk;
   current_channel_sample_path DUT (.sys_clk(sys_clk), .rst(rst),
      .adc_phase_a(adc_a), .adc_phase_b(adc_b), .adc_phase_c(adc_c),
      .adc_strobe(adc_strobe), .reg_valid(reg_valid), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .byte_read(byte_read), .reg_rdata(reg_rdata),
      .reg_rvalid(reg_rvalid), .current_gain(current_gain),
      .voltage_gain(voltage_gain), .modulator_clock(modulator_clock),
      .energy_sample_a(energy_sample_a), .energy_sample_b(energy_sample_b),
      .energy_sample_c(energy_sample_c), .irq_n_out(irq_n_out),
      .irq_n_oe(irq_n_oe));
   host_model host (.sys_clk(sys_clk), .reg_valid(reg_valid),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .byte_read(byte_read));
   task automatic check_word(input logic [23:0] got, exp, input string what);
      samples_checked++;
      if (got !== exp) begin
         n_errors++;
         $display("CHECK FAILED %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask
   task automatic results();
      $display("checks %0d errors %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   function automatic logic [23:0] scaled(logic [23:0] v, logic [11:0] g);
      logic signed [47:0] s;
      s = $signed(v) + (($signed(v) * $signed(g)) >>> 12);
      if (s > clamp_pos)
         s = clamp_pos;
      if (s < clamp_neg)
         s = clamp_neg;
      return s[23:0];
   endfunction
   task automatic wr(input logic [7:0] a, input logic [23:0] d);
      host.access(write_flag | a, d);
   endtask
   task automatic rd_exp(input logic [7:0] a, input logic [7:0] e);
      exp_q.push_back({16'h0, e});
      host.access(a, 24'h0);
   endtask
   task automatic set_gains(input logic [11:0] g0, g1, g2);
      gn = '{g0, g1, g2};
      for (int i = 0; i < 3; i++)
         wr(addr_phase_a_gain + 8'(i), {12'h000, gn[i]});
   endtask
   task automatic strobe(input logic [23:0] a, b, c);
      @(posedge sys_clk);
      adc_a      <= a;
      adc_b      <= b;
      adc_c      <= c;
      adc_strobe <= 1'b1;
      en_q.push_back(scaled(a, gn[0]));
      en_q.push_back(scaled(b, gn[1]));
      en_q.push_back(scaled(c, gn[2]));
      @(posedge sys_clk);
      adc_strobe <= 1'b0;
      repeat (4) @(posedge sys_clk);
   endtask
   task automatic wait_irq(output int t);
      int n;
      n = 0;
      repeat (2) @(posedge sys_clk);
      while (irq_pin !== 1'b0 && n < 8000) begin
         @(negedge sys_clk);
         n++;
      end
      if (n >= 8000) begin
         n_errors++;
         $display("CHECK FAILED %0t no interrupt", $time);
      end
      t = cyc;
   endtask
   always @(posedge sys_clk) begin
      cyc   <= cyc + 1;
      stb_d <= {stb_d[1:0], adc_strobe};
   end
   always @(negedge sys_clk) begin
      if (reg_rvalid === 1'b1) begin
         if (exp_q.size() == 0) begin
            n_errors++;
            $display("CHECK FAILED %0t unexpected answer", $time);
         end else
            check_word({16'h0, reg_rdata}, exp_q.pop_front(), "rd");
      end
      if (stb_d[2]) begin
         check_word(energy_sample_a, en_q.pop_front(), "phase a");
         check_word(energy_sample_b, en_q.pop_front(), "phase b");
         check_word(energy_sample_c, en_q.pop_front(), "phase c");
      end
   end
   initial begin
      repeat (60000) @(posedge sys_clk);
      n_errors++;
      $display("CHECK FAILED %0t watchdog", $time);
      results();
   end
   initial begin
      logic [23:0] v, va, vb;
      logic [23:0] tbl[4];
      int t0, t1;
      tbl = '{full_scale_pos, full_scale_neg, 24'h7fffff, 24'h800000};
      void'($urandom(72927));
      repeat (12) @(posedge sys_clk);
      rst <= 1'b0;
      // ======================================================
      // gain fields, unmapped offsets
      for (int g = 0; g < 4; g++) begin
         wr(addr_analog_gain, 24'(g | (g << 5)));
         // register lands on the take edge, pga output one edge later
         repeat (2) @(negedge sys_clk);
         check_word({22'h0, current_gain}, 24'(g), "cur gain");
         check_word({22'h0, voltage_gain}, 24'(g), "volt gain");
      end
      host.access(8'h0f, 24'h0);
      wr(8'h0f, 24'h0);
      rd_exp(addr_reset_status, 8'h00);
      $display("gain test done");
      // ======================================================
      // per-phase scaling and clamping
      set_gains(12'h7ff, 12'h800, 12'h000);
      for (int i = 0; i < 8; i++) begin
         v = (i < 4) ? tbl[i] : 24'($urandom);
         strobe(v, v, v);
      end
      $display("scaling test done");
      // ======================================================
      // phase routing, mask, fifo fill and drain
      set_gains(12'h000, 12'h000, 12'h000);
      va = 24'($urandom);
      vb = ~va;
      strobe(va, vb, va);
      wr(addr_waveform_mode, 24'h000000);
      repeat (800) @(negedge sys_clk);
      check_word({23'h0, irq_pin}, 24'h1, "masked");
      wr(addr_waveform_mode, 24'h000001);
      wr(addr_irq_mask, 24'h000001);
      repeat (17 * base_period_cycles + 100) @(posedge sys_clk);
      rd_exp(addr_reset_status, 8'h01);
      repeat (500) @(negedge sys_clk);
      check_word({23'h0, irq_pin}, 24'h1, "full quiet");
      wr(addr_irq_mask, 24'h000000);
      v = scaled(vb, 12'h000);
      repeat (fifo_depth) begin
         exp_q.push_back({16'h0, v[23:16]});
         exp_q.push_back({16'h0, v[15:8]});
         exp_q.push_back({16'h0, v[7:0]});
         host.read_sample();
      end
      $display("fifo test done");
      // ======================================================
      // sample rates and interrupt timing
      wr(addr_irq_mask, 24'h000001);
      for (int r = 0; r < 4; r++) begin
         wr(addr_waveform_mode, 24'(r << rate_select_lsb));
         wait_irq(t0);
         rd_exp(addr_reset_status, 8'h01);
         wait_irq(t0);
         rd_exp(addr_reset_status, 8'h01);
         wait_irq(t1);
         rd_exp(addr_reset_status, 8'h01);
         t1 = t1 - t0;
         t0 = base_period_cycles << r;
         check_word(24'(t1), 24'(t0), "period");
         strobe(24'($urandom), va, vb);
      end
      $display("rate test done");
      results();
   end
endmodule
bind current_channel_sample_path sample_path_checker u_chk (
   .sys_clk(sys_clk), .rst(rst), .reg_valid(reg_valid),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .byte_read(byte_read),
   .reg_rvalid(reg_rvalid), .current_gain(current_gain),
   .voltage_gain(voltage_gain), .modulator_clock(modulator_clock),
   .energy_sample_a(energy_sample_a), .energy_sample_b(energy_sample_b),
   .energy_sample_c(energy_sample_c), .irq_n_out(irq_n_out),
   .irq_n_oe(irq_n_oe));
